/* File: hw/srap_device.sv */
// device end: serial slave, register map, sram working copy and flash image
// Summary of operation
// - link works only while chip select asserted
// - sample input on rise, shift output on fall
// - mode 3, msb first, 16-bit full duplex
// - master keeps clock at most 2.5 mhz
// - 16-bit registers with two byte addresses
// - upper byte address is lower plus one
// - sram working copy, flash on store
// - flash copied into sram after reset
// - each write frame to a writable register updates one byte
// - global bit zero starts bias null
// - read data returns in next frame
// - either byte address reads whole register
// - read during return frame is pipelined
// - unused addresses reserved, read zero
// - misc control low bits select data ready
// - read-only flash write counter register
// - read-only flash-backed part identifier
// - chip select is active low
// - msb presented at chip select fall
// - output released after chip select rises
`timescale 1ns/10ps
module srap_device #(
   parameter logic [15:0] PART_CODE   = 16'h1234,   // arbitrary value
   parameter logic [15:0] LOT_FIRST   = 16'h0101,   // arbitrary value
   parameter logic [15:0] LOT_SECOND  = 16'h0202,   // arbitrary value
   parameter logic [15:0] SERIAL_CODE = 16'h0303    // arbitrary value
) (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        por_n,
   srap_if.device           link,
   input  wire logic [15:0] supply_meas,
   input  wire logic [15:0] rate_meas,
   input  wire logic [15:0] aux_meas,
   input  wire logic [15:0] temp_meas,
   input  wire logic [15:0] diag_meas,
   output logic             cfg_loaded_ff,
   output logic             autonull_start_ff,
   output logic             flash_store_ff,
   output logic [2:0]       drdy_sel_ff
);
   logic [2:0]           pin_sync_ff;                          // synced sclk, cs_n, mosi
   logic                 sclk_d_ff;                            // last synced clock
   logic                 cs_d_ff;                              // last synced select
   logic [3:0]           bit_cnt_ff;                           // bits taken in frame
   logic [14:0]          rx_sh_ff;                             // receive shifter
   logic                 frm_done_ff;                          // frame complete pulse
   logic [15:0]          frm_ff;                               // last complete frame
   logic [15:0]          tx_sh_ff;                             // transmit shifter
   logic [15:0]          tx_word_ff;                           // answer for next frame
   logic                 oe_ff;                                // output enable
   logic [15:0]          sram_ff  [0:srap_pkg::NUM_WORDS-1];   // working copy
   logic [15:0]          flash_ff [0:srap_pkg::NUM_WORDS-1];   // nonvolatile image
   srap_pkg::srap_load_t load_st_ff;                           // boot copy state
   logic [5:0]           load_idx_ff;                          // boot copy slot
   logic [15:0]          rd_word;                              // read mux result
   logic                 s_sclk, s_cs_n, s_mosi;
   logic                 active, sclk_rise, sclk_fall, cs_fall;
   logic                 frm_wr, frm_hi, loaded, wr_ok, glob_wr, do_store;
   logic [5:0]           frm_idx;
   logic [7:0]           frm_data;
   logic [2:0]           frm_attr, ld_attr;

   localparam logic [5:0] IDX_CNT = srap_pkg::OFS_FLASH_WRITE_COUNTER[6:1];

   // factory image of the flash
   function automatic logic [15:0] flash_default(input logic [5:0] idx);
      case (idx)
         srap_pkg::OFS_SCALE[6:1]:  flash_default = srap_pkg::RST_SCALE;
         srap_pkg::OFS_SMPL[6:1]:   flash_default = srap_pkg::RST_SMPL;
         srap_pkg::OFS_RANGE[6:1]:  flash_default = srap_pkg::RST_RANGE;
         srap_pkg::OFS_LOT1[6:1]:   flash_default = LOT_FIRST;
         srap_pkg::OFS_LOT2[6:1]:   flash_default = LOT_SECOND;
         srap_pkg::OFS_PART[6:1]:   flash_default = PART_CODE;
         srap_pkg::OFS_SERIAL[6:1]: flash_default = SERIAL_CODE;
         default:                   flash_default = srap_pkg::RST_ZERO;
      endcase
   endfunction : flash_default

   // pins are foreign to mclk, idle high clock and select
   srap_sync #(.WIDTH(3), .RST_VAL(3'h6)) u_pin_sync (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .async_in ({link.sclk, link.cs_n, link.mosi}),
      .sync_ff  (pin_sync_ff)
   );

   assign {s_sclk, s_cs_n, s_mosi} = pin_sync_ff;
   assign active    = ~s_cs_n;
   assign sclk_rise = active & s_sclk & ~sclk_d_ff;
   assign sclk_fall = active & ~s_sclk & sclk_d_ff;
   assign cs_fall   = ~s_cs_n & cs_d_ff;
   assign link.dout    = tx_sh_ff[15];
   assign link.dout_oe = oe_ff;

   // frame fields: direction, byte address, data byte
   assign frm_wr   = frm_ff[srap_pkg::FRM_RW_POS];
   assign frm_idx  = frm_ff[14:9];
   assign frm_hi   = frm_ff[8];
   assign frm_data = frm_ff[7:0];
   assign frm_attr = srap_pkg::srap_attr(frm_idx);
   assign ld_attr  = srap_pkg::srap_attr(load_idx_ff);
   assign loaded   = (load_st_ff == srap_pkg::LD_RUN);
   // writes wait for the boot copy so they are not overwritten
   assign wr_ok    = frm_done_ff & frm_wr & loaded
                     & ((frm_attr & srap_pkg::ATTR_RW) != 3'h0);
   assign glob_wr  = frm_done_ff & frm_wr & loaded & ~frm_hi
                     & (frm_idx == srap_pkg::OFS_GLOBAL[6:1]);
   assign do_store = glob_wr & frm_data[srap_pkg::GCMD_STORE];

   // edge history of the synced pins
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_d_ff <= 1'b1;
         cs_d_ff   <= 1'b1;
      end else begin
         sclk_d_ff <= s_sclk;
         cs_d_ff   <= s_cs_n;
      end
   end

   // receive shifter, a deselect drops any partial frame
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         bit_cnt_ff  <= 4'h0;
         rx_sh_ff    <= 15'h0000;
         frm_done_ff <= 1'b0;
         frm_ff      <= 16'h0000;
      end else begin
         frm_done_ff <= 1'b0;
         if (!active) begin
            bit_cnt_ff <= 4'h0;
         end else if (sclk_rise) begin
            rx_sh_ff <= {rx_sh_ff[13:0], s_mosi};
            if (bit_cnt_ff == srap_pkg::FRAME_LAST) begin
               bit_cnt_ff  <= 4'h0;
               frm_ff      <= {rx_sh_ff, s_mosi};
               frm_done_ff <= 1'b1;
            end else begin
               bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end
         end
      end
   end

   // transmit shifter; first fall of a frame keeps the msb
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tx_sh_ff <= 16'h0000;
         oe_ff    <= 1'b0;
      end else begin
         oe_ff <= active;
         if (cs_fall || (sclk_fall && bit_cnt_ff == 4'h0)) begin
            tx_sh_ff <= tx_word_ff;
         end else if (sclk_fall) begin
            tx_sh_ff <= {tx_sh_ff[14:0], 1'b0};
         end
      end
   end

   // read mux, whole word for either byte address
   always_comb begin
      rd_word = 16'h0000;
      case (frm_idx)
         srap_pkg::OFS_SUPPLY[6:1]:  rd_word = supply_meas;
         srap_pkg::OFS_RATE[6:1]:    rd_word = rate_meas;
         srap_pkg::OFS_AUX_ADC[6:1]: rd_word = aux_meas;
         srap_pkg::OFS_TEMP[6:1]:    rd_word = temp_meas;
         srap_pkg::OFS_DIAG[6:1]:    rd_word = diag_meas;
         default: begin
            if ((frm_attr & srap_pkg::ATTR_RD) != 3'h0) begin
               rd_word = sram_ff[frm_idx];
            end
         end
      endcase
   end

   // answer word, every frame replaces it so reads pipeline
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tx_word_ff <= 16'h0000;
      end else if (frm_done_ff) begin
         tx_word_ff <= frm_wr ? 16'h0000 : rd_word;
      end
   end

   // boot copy walks every slot once after reset
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         load_st_ff    <= srap_pkg::LD_COPY;
         load_idx_ff   <= 6'h00;
         cfg_loaded_ff <= 1'b0;
      end else begin
         case (load_st_ff)
            srap_pkg::LD_COPY: begin
               load_idx_ff <= load_idx_ff + 6'h01;
               if (load_idx_ff == srap_pkg::IDX_LAST) begin
                  load_st_ff    <= srap_pkg::LD_RUN;
                  cfg_loaded_ff <= 1'b1;
               end
            end
            srap_pkg::LD_RUN:  cfg_loaded_ff <= 1'b1;
            default:           load_st_ff    <= srap_pkg::LD_COPY;
         endcase
      end
   end

   // working copy: boot load, byte writes, counter follows a store
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < srap_pkg::NUM_WORDS; i++) begin
            sram_ff[i] <= 16'h0000;
         end
      end else if (!loaded) begin
         if ((ld_attr & srap_pkg::ATTR_FLASH) != 3'h0) begin
            sram_ff[load_idx_ff] <= flash_ff[load_idx_ff];
         end
      end else if (wr_ok) begin
         if (frm_hi) begin
            sram_ff[frm_idx][15:8] <= frm_data;
         end else begin
            sram_ff[frm_idx][7:0]  <= frm_data;
         end
      end else if (do_store) begin
         sram_ff[IDX_CNT] <= sram_ff[IDX_CNT] + 16'h0001;
      end
   end

   // flash image, cleared to factory values only at power-on
   always_ff @(posedge mclk or negedge por_n) begin
      if (!por_n) begin
         for (int i = 0; i < srap_pkg::NUM_WORDS; i++) begin
            flash_ff[i] <= flash_default(6'(i));
         end
      end else if (do_store) begin
         for (int i = 0; i < srap_pkg::NUM_WORDS; i++) begin
            if ((srap_pkg::srap_attr(6'(i)) & srap_pkg::ATTR_RW) != 3'h0 &&
                (srap_pkg::srap_attr(6'(i)) & srap_pkg::ATTR_FLASH) != 3'h0) begin
               flash_ff[i] <= sram_ff[i];
            end
         end
         flash_ff[IDX_CNT] <= flash_ff[IDX_CNT] + 16'h0001;
      end
   end

   // command pulses and data-ready line selection
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         autonull_start_ff <= 1'b0;
         flash_store_ff    <= 1'b0;
         drdy_sel_ff       <= 3'h0;
      end else begin
         autonull_start_ff <= glob_wr & frm_data[srap_pkg::GCMD_AUTONULL];
         flash_store_ff    <= do_store;
         drdy_sel_ff <= sram_ff[srap_pkg::OFS_MISC[6:1]][srap_pkg::MISC_DRDY_MSB:0];
      end
   end
endmodule : srap_device

/* File: hw/srap_pkg.sv */
// shared constants, register map and types of the spi register access port
package srap_pkg;
   // frame layout
   localparam int         FRM_RW_POS   = 15;             // one = write, zero = read
   localparam logic [3:0] FRAME_LAST   = 4'hf;           // bit count of the 16th bit
   localparam logic [4:0] FRAME_BITS   = 5'h10;          // bits in one frame
   localparam int         NUM_WORDS    = 64;             // word slots for 7-bit byte addresses
   localparam logic [5:0] IDX_LAST     = 6'h3f;          // last word slot

   // byte offsets of the lower byte of each register
   localparam logic [6:0] OFS_FLASH_WRITE_COUNTER = 7'h00;
   localparam logic [6:0] OFS_SUPPLY    = 7'h02;
   localparam logic [6:0] OFS_RATE      = 7'h04;
   localparam logic [6:0] OFS_AUX_ADC   = 7'h0a;
   localparam logic [6:0] OFS_TEMP      = 7'h0c;
   localparam logic [6:0] OFS_ANGLE     = 7'h0e;
   localparam logic [6:0] OFS_BIAS      = 7'h14;
   localparam logic [6:0] OFS_SCALE     = 7'h16;
   localparam logic [6:0] OFS_ALM1_MAG  = 7'h20;
   localparam logic [6:0] OFS_ALM2_MAG  = 7'h22;
   localparam logic [6:0] OFS_ALM1_WIN  = 7'h24;
   localparam logic [6:0] OFS_ALM2_WIN  = 7'h26;
   localparam logic [6:0] OFS_ALARM_CONTROL  = 7'h28;
   localparam logic [6:0] OFS_DAC       = 7'h30;
   localparam logic [6:0] OFS_DIO_CTRL  = 7'h32;
   localparam logic [6:0] OFS_MISC      = 7'h34;
   localparam logic [6:0] OFS_SMPL      = 7'h36;
   localparam logic [6:0] OFS_RANGE     = 7'h38;
   localparam logic [6:0] OFS_SLEEP     = 7'h3a;
   localparam logic [6:0] OFS_DIAG      = 7'h3c;
   localparam logic [6:0] OFS_GLOBAL    = 7'h3e;
   localparam logic [6:0] OFS_LOT1      = 7'h52;
   localparam logic [6:0] OFS_LOT2      = 7'h54;
   localparam logic [6:0] OFS_PART      = 7'h56;
   localparam logic [6:0] OFS_SERIAL    = 7'h58;

   // values after reset of the flash image
   localparam logic [15:0] RST_ZERO  = 16'h0000;
   localparam logic [15:0] RST_SCALE = 16'h0800;
   localparam logic [15:0] RST_SMPL  = 16'h0001;
   localparam logic [15:0] RST_RANGE = 16'h0402;

   // global command bits and misc control field
   localparam int GCMD_AUTONULL = 0;
   localparam int GCMD_STORE    = 3;
   localparam int MISC_DRDY_MSB = 2;

   // register attributes
   localparam logic [2:0] ATTR_RD    = 3'h4;             // read from working copy
   localparam logic [2:0] ATTR_RW    = 3'h2;             // software writable
   localparam logic [2:0] ATTR_FLASH = 3'h1;             // flash backed

   // link timing
   localparam int MCLK_PERIOD_NS     = 8;
   localparam int SCLK_MIN_PERIOD_NS = 400;              // 2.5 mhz ceiling
   localparam int STALL_NS           = 1000;             // gap between frames
   localparam logic [15:0] SCLK_HALF_CYC =
      16'((SCLK_MIN_PERIOD_NS + 2 * MCLK_PERIOD_NS - 1) / (2 * MCLK_PERIOD_NS));
   localparam logic [15:0] STALL_CYC =
      16'((STALL_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);

   // avalon byte offsets of the master's own registers
   localparam logic [3:0] AV_CMD    = 4'h0;
   localparam logic [3:0] AV_STATUS = 4'h4;
   localparam logic [3:0] AV_RXDATA = 4'h8;

   typedef enum logic {LD_COPY, LD_RUN} srap_load_t;
   typedef enum logic [2:0] {M_IDLE, M_LEAD, M_LOW, M_HIGH, M_TRAIL, M_STALL} srap_mst_t;

   // attributes of one word slot
   function automatic logic [2:0] srap_attr(input logic [5:0] idx);
      case (idx)
         OFS_FLASH_WRITE_COUNTER[6:1], OFS_LOT1[6:1], OFS_LOT2[6:1], OFS_PART[6:1],
         OFS_SERIAL[6:1]:    srap_attr = ATTR_RD | ATTR_FLASH;
         OFS_BIAS[6:1], OFS_SCALE[6:1], OFS_ALM1_MAG[6:1], OFS_ALM2_MAG[6:1],
         OFS_ALM1_WIN[6:1], OFS_ALM2_WIN[6:1], OFS_ALARM_CONTROL[6:1], OFS_MISC[6:1],
         OFS_SMPL[6:1], OFS_RANGE[6:1],
         OFS_SLEEP[6:1]:     srap_attr = ATTR_RD | ATTR_RW | ATTR_FLASH;
         OFS_ANGLE[6:1], OFS_DAC[6:1],
         OFS_DIO_CTRL[6:1]:  srap_attr = ATTR_RD | ATTR_RW;
         default:            srap_attr = 3'h0;
      endcase
   endfunction : srap_attr
endpackage : srap_pkg

/* File: hw/srap_if.sv */
// four-wire serial link between master and device
`timescale 1ns/10ps
interface srap_if;
   logic sclk;      // serial clock, idles high
   logic cs_n;      // chip select, active low
   logic mosi;      // master out, device in
   logic dout;      // device output bit
   logic dout_oe;   // device drives dout
   logic miso;      // resolved line as the master sees it

   // a released line reads as its pull-up level, so no floating value is modelled
   assign miso = dout_oe ? dout : 1'b1;

   modport device (input sclk, input cs_n, input mosi, output dout, output dout_oe);
   modport master (output sclk, output cs_n, output mosi, input miso);
endinterface : srap_if

/* File: hw/srap_sync.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module srap_sync #(
   parameter int               WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             mclk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_ff
);
   logic [WIDTH-1:0] meta_ff;   // first stage, read only by sync_ff

   // two stages, idle level at reset
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= RST_VAL;
         sync_ff <= RST_VAL;
      end else begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end
endmodule : srap_sync

/* File: hw/srap_master.sv */
// master end: avalon command registers driving 16-bit mode 3 frames
`timescale 1ns/10ps
module srap_master (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   srap_if.master           link,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest
);
   logic                srap_miso_s;   // synced device output
   logic                sclk_ff;       // serial clock, idles high
   logic                cs_n_ff;       // chip select
   logic                mosi_ff;       // serial data out
   srap_pkg::srap_mst_t st_ff;         // frame sequencer
   logic [15:0]         timer_ff;      // half period and stall timer
   logic [4:0]          bits_ff;       // rising edges given
   logic [15:0]         tx_ff;         // outgoing frame
   logic [15:0]         rx_ff;         // incoming frame
   logic [15:0]         rxdata_ff;     // last full received word
   logic                busy_ff;       // frame or stall in progress
   logic                hit_cmd, acc_ok, start;

   srap_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_miso_sync (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .async_in (link.miso),
      .sync_ff  (srap_miso_s)
   );

   assign link.sclk = sclk_ff;
   assign link.cs_n = cs_n_ff;
   assign link.mosi = mosi_ff;

   // a new command while busy is held off by waitrequest
   assign hit_cmd = avs_write & (avs_address == srap_pkg::AV_CMD);
   assign acc_ok  = (avs_read | avs_write) & ~(hit_cmd & busy_ff);
   assign start   = hit_cmd & ~avs_waitrequest;

   // avalon slave: waitrequest drops one cycle after the request
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
      end else if (avs_waitrequest && acc_ok) begin
         avs_waitrequest <= 1'b0;
         case (avs_address)
            srap_pkg::AV_STATUS: avs_readdata <= {31'h0, busy_ff};
            srap_pkg::AV_RXDATA: avs_readdata <= {16'h0000, rxdata_ff};
            default:             avs_readdata <= 32'h0000_0000;
         endcase
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   // frame sequencer; half period keeps sclk at or below the ceiling
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff     <= srap_pkg::M_IDLE;
         timer_ff  <= 16'h0000;
         bits_ff   <= 5'h00;
         sclk_ff   <= 1'b1;
         cs_n_ff   <= 1'b1;
         mosi_ff   <= 1'b0;
         tx_ff     <= 16'h0000;
         rx_ff     <= 16'h0000;
         rxdata_ff <= 16'h0000;
         busy_ff   <= 1'b0;
      end else begin
         if (timer_ff != 16'h0000) begin
            timer_ff <= timer_ff - 16'h0001;
         end
         case (st_ff)
            srap_pkg::M_IDLE: begin
               if (start) begin
                  busy_ff  <= 1'b1;
                  cs_n_ff  <= 1'b0;
                  tx_ff    <= avs_writedata[15:0];
                  timer_ff <= srap_pkg::SCLK_HALF_CYC - 16'h0001;
                  st_ff    <= srap_pkg::M_LEAD;
               end
            end
            srap_pkg::M_LEAD, srap_pkg::M_HIGH: begin
               if (timer_ff == 16'h0000) begin
                  timer_ff <= srap_pkg::SCLK_HALF_CYC - 16'h0001;
                  if (bits_ff == srap_pkg::FRAME_BITS) begin
                     st_ff <= srap_pkg::M_TRAIL;
                  end else begin
                     sclk_ff <= 1'b0;
                     mosi_ff <= tx_ff[15];
                     tx_ff   <= {tx_ff[14:0], 1'b0};
                     st_ff   <= srap_pkg::M_LOW;
                  end
               end
            end
            srap_pkg::M_LOW: begin
               if (timer_ff == 16'h0000) begin
                  sclk_ff  <= 1'b1;
                  rx_ff    <= {rx_ff[14:0], srap_miso_s};
                  bits_ff  <= bits_ff + 5'h01;
                  timer_ff <= srap_pkg::SCLK_HALF_CYC - 16'h0001;
                  st_ff    <= srap_pkg::M_HIGH;
               end
            end
            srap_pkg::M_TRAIL: begin
               if (timer_ff == 16'h0000) begin
                  cs_n_ff   <= 1'b1;
                  rxdata_ff <= rx_ff;
                  bits_ff   <= 5'h00;
                  timer_ff  <= srap_pkg::STALL_CYC - 16'h0001;
                  st_ff     <= srap_pkg::M_STALL;
               end
            end
            srap_pkg::M_STALL: begin
               if (timer_ff == 16'h0000) begin
                  busy_ff <= 1'b0;
                  st_ff   <= srap_pkg::M_IDLE;
               end
            end
            default: st_ff <= srap_pkg::M_IDLE;
         endcase
      end
   end
endmodule : srap_master

/* File: bench/srap_link_asserts.sv */
// assertions on the four-wire link between the two ends
`timescale 1ns/10ps
module srap_link_asserts (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic dout,
   input wire logic dout_oe,
   input wire logic miso
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // long deselected span, device must have let go by then
   sequence s_idle;
      cs_n [*8];
   endsequence
   idle_clk_high_a: assert property (cs_n |-> sclk) else $error("clock not idle high");
   oe_release_a: assert property (s_idle |-> !dout_oe) else $error("output held");
   miso_pull_a: assert property (!dout_oe |-> miso) else $error("released line low");
   msb_drive_a: assert property ($fell(cs_n) |-> ##[1:6] dout_oe) else $error("no drive");
   select_lead_a: assert property ($fell(cs_n) |-> sclk [*8]) else $error("short lead");
   low_phase_a: assert property ($fell(sclk) |-> !sclk [*8]) else $error("clock too fast");
   clk_in_frame_a: assert property ($fell(sclk) |-> !cs_n) else $error("clock unselected");
   din_stable_a: assert property ($rose(sclk) |-> $stable(mosi)) else $error("mosi moved");
   dout_stable_a: assert property ($rose(sclk) && dout_oe |-> $stable(dout))
      else $error("dout moved at rise");
endmodule : srap_link_asserts

/* File: bench/spi_register_access_port_test.sv */
// self-checking bench: both ends joined, avalon side driven
`timescale 1ns/10ps
module spi_register_access_port_test;
   logic        mclk, rst_n, por_n, cfg_loaded_ff, autonull_start_ff, flash_store_ff;
   logic [2:0]  drdy_sel_ff;
   logic [3:0]  avs_address;
   logic        avs_read, avs_write, avs_waitrequest;
   logic [31:0] avs_writedata, avs_readdata;
   logic [15:0] rate_meas, base, r;
   int          err_total, num_checks, an_cnt, st_cnt;
   srap_if link_if();
   srap_device #(.PART_CODE(16'h4321)) i_srap_device (.mclk(mclk), .rst_n(rst_n),
      .por_n(por_n), .link(link_if.device), .supply_meas(16'h0aaa), .rate_meas(rate_meas),
      .aux_meas(16'h07ae), .temp_meas(16'h0001), .diag_meas(16'h0000),
      .cfg_loaded_ff(cfg_loaded_ff), .autonull_start_ff(autonull_start_ff),
      .flash_store_ff(flash_store_ff), .drdy_sel_ff(drdy_sel_ff));
   srap_master i_srap_master (.mclk(mclk), .rst_n(rst_n), .link(link_if.master),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));
   srap_link_asserts i_srap_link_asserts (.mclk(mclk), .rst_n(rst_n), .sclk(link_if.sclk),
      .cs_n(link_if.cs_n), .mosi(link_if.mosi), .dout(link_if.dout),
      .dout_oe(link_if.dout_oe), .miso(link_if.miso));
   // free-running system clock
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // count one-cycle command pulses
   always @(posedge mclk) begin
      if (autonull_start_ff === 1'b1) an_cnt++;
      if (flash_store_ff === 1'b1) st_cnt++;
   end
   task chk(input logic [15:0] g, input logic [15:0] e);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   // one avalon access, held until waitrequest is seen low
   task av(input logic [3:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
      @(posedge mclk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= ~w;
      avs_writedata <= d;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : av
   // send one frame, wait for idle, return word of the previous read
   task xfer(input logic [15:0] f, output logic [15:0] w);
      logic [31:0] q;
      av(4'h0, 1'b1, {16'h0000, f}, q);
      do av(4'h4, 1'b0, 32'h0, q); while (q[0] !== 1'b0);
      av(4'h8, 1'b0, 32'h0, q);
      w = q[15:0];
   endtask : xfer
   // byte writes, both byte addresses, pipelined reads, read-only write
   task t_bytes;
      xfer(16'h9434, r);
      xfer(16'h9512, r); chk(r, 16'h0000);
      xfer(16'h1500, r); chk(r, 16'h0000);
      xfer(16'h1400, r); chk(r, 16'h1234);
      xfer(16'h1600, r); chk(r, 16'h1234);
      xfer(16'hd6ff, r); chk(r, 16'h0800);
      xfer(16'h5700, r); chk(r, 16'h0000);
      xfer(16'h0600, r); chk(r, 16'h4321);
      xfer(16'h3e00, r); chk(r, 16'h0000);
      xfer(16'h0500, r); chk(r, 16'h0000);
   endtask : t_bytes
   // autonull and store in one word, counter and data-ready select
   task t_cmds;
      xfer(16'h0000, r); chk(r, rate_meas);
      xfer(16'hbe09, base);
      xfer(16'h0000, r); chk(r, 16'h0000);
      xfer(16'hb405, r); chk(r, base + 16'h0001);
      xfer(16'h3500, r); chk(16'(an_cnt), 16'h0001);
      chk(16'(st_cnt), 16'h0001);
      chk({13'h0, drdy_sel_ff}, 16'h0005);
      xfer(16'h0000, r); chk(r, 16'h0005);
   endtask : t_cmds
   // warm reset keeps flash, reloads sram, clears plain registers
   task t_reload;
      xfer(16'h8e77, r);
      xfer(16'h0e00, r); chk(r, 16'h0000);
      xfer(16'h1400, r); chk(r, 16'h0077);
      rst_n <= 1'b0;
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      for (int i = 0; i < 200 && cfg_loaded_ff !== 1'b1; i++) @(posedge mclk);
      chk({15'h0, cfg_loaded_ff}, 16'h0001);
      xfer(16'h0e00, r); chk(r, 16'h0000);
      xfer(16'h1400, r); chk(r, 16'h0000);
      xfer(16'h0000, r); chk(r, 16'h1234);
      xfer(16'h0000, r); chk(r, base + 16'h0001);
   endtask : t_reload
   task summarize;
      if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : summarize
   // hang guard, about three times the twenty-three frames of the run
   initial begin
      #600000;
      err_total++;
      summarize;
   end
   initial begin
      {rst_n, por_n, avs_read, avs_write} = 4'h0;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      rate_meas = 16'ha5c3;
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      por_n <= 1'b1;
      for (int i = 0; i < 200 && cfg_loaded_ff !== 1'b1; i++) @(posedge mclk);
      t_bytes;
      t_cmds;
      t_reload;
      summarize;
   end
endmodule : spi_register_access_port_test
